// [verilog/fsktm_pkg.sv]
// Shared constants of the two-tone frequency-shift-keyed modem core.
// Behaviour
// - With request low, a data-selected tone clock steps the sine address.
// - Data high selects the 1200 Hz low-tone clock, data low the high tone.
// - Terminal value is clock over tone times table length, minus one.
// - Demodulator times comparator half-cycles to decide the incoming tone.
// - Two classifiers, 2200 Hz and 1200 Hz; either triggers the one-shot.
// - The one-shot emits one fixed pulse per bit, one 1200 baud bit long.
// - A different reference rate recomputes both tone terminal values.
// - Carrier detect is active low, asserted while either tone is received.
// - Carrier starts and stops within five bit times of request changes.
package fsktm_pkg;

  // ===========================================================================
  // Clock and line rates
  localparam int FSKTM_CLK_HZ = 32'h05F5_E100;
  localparam int FSKTM_CLK_PERIOD_NS = 32'h0000_000A;
  localparam int FSKTM_REF_NOMINAL_HZ = 32'h003D_0900;
  localparam int FSKTM_REF_MIN_HZ = 32'h0007_5300;
  localparam int FSKTM_LOW_TONE_HZ = 32'h0000_04B0;
  localparam int FSKTM_HIGH_TONE_HZ = 32'h0000_0898;
  localparam int FSKTM_BAUD = 32'h0000_04B0;
  localparam int FSKTM_START_STOP_BITS = 32'h0000_0005;

  // ===========================================================================
  // Demodulator tolerance in percent of the nominal half-cycle.
  localparam int FSKTM_TOL_PCT = 32'h0000_000A;
  localparam int FSKTM_PCT_FULL = 32'h0000_0064;

  // ===========================================================================
  // Sine table layout
  localparam int FSKTM_SINE_WORDS = 32'h0000_0064;
  localparam int FSKTM_ADDR_W = 32'h0000_0007;
  localparam int FSKTM_SAMPLE_W = 32'h0000_0008;
  localparam logic [6:0] FSKTM_ADDR_LAST = 7'(FSKTM_SINE_WORDS - 1);
  localparam logic [6:0] FSKTM_ADDR_HALF = 7'(FSKTM_SINE_WORDS / 2);
  localparam logic [6:0] FSKTM_ADDR_QTR = 7'(FSKTM_SINE_WORDS / 4);
  localparam logic [6:0] FSKTM_ADDR_Q3 = 7'(3 * FSKTM_SINE_WORDS / 4);
  localparam logic [6:0] FSKTM_ADDR_FULL = 7'(FSKTM_SINE_WORDS);
  localparam logic [7:0] FSKTM_MID = 8'h80;
  localparam logic [8:0] FSKTM_WRAP = 9'h100;

endpackage : fsktm_pkg

// [verilog/fsktm_sine_rom.sv]
// Quarter-wave sine table with a registered read port.
`timescale 1ns/1ps
module fsktm_sine_rom import fsktm_pkg::*; (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // Read port
  input wire logic [6:0] addr_i,
  output logic [7:0] data_o
);

  typedef struct packed {
    logic [7:0] q;
  } fsktm_rom_st_t;

  fsktm_rom_st_t st_r;
  fsktm_rom_st_t st_nxt;

  // ===========================================================================
  // Only one quarter is stored; symmetry rebuilds the rest, which costs a
  // little folding logic but keeps the table short.
  function automatic logic [7:0] qtr_val(input logic [6:0] i);
    logic [7:0] v;
    v = FSKTM_MID;
    unique case (i)
      7'h00: v = 8'h80;
      7'h01: v = 8'h88;
      7'h02: v = 8'h90;
      7'h03: v = 8'h98;
      7'h04: v = 8'hA0;
      7'h05: v = 8'hA7;
      7'h06: v = 8'hAF;
      7'h07: v = 8'hB6;
      7'h08: v = 8'hBD;
      7'h09: v = 8'hC4;
      7'h0A: v = 8'hCB;
      7'h0B: v = 8'hD1;
      7'h0C: v = 8'hD7;
      7'h0D: v = 8'hDD;
      7'h0E: v = 8'hE2;
      7'h0F: v = 8'hE7;
      7'h10: v = 8'hEB;
      7'h11: v = 8'hEF;
      7'h12: v = 8'hF3;
      7'h13: v = 8'hF6;
      7'h14: v = 8'hF9;
      7'h15: v = 8'hFB;
      7'h16: v = 8'hFD;
      7'h17: v = 8'hFE;
      7'h18: v = 8'hFF;
      7'h19: v = 8'hFF;
      default: v = FSKTM_MID;
    endcase
    return v;
  endfunction : qtr_val

  // ===========================================================================
  // Fold and register
  always_comb begin
    logic [6:0] q;
    logic [7:0] v;
    q = '0;
    v = '0;
    st_nxt = st_r;
    if (addr_i <= FSKTM_ADDR_QTR) begin
      q = addr_i;
    end else if (addr_i <= FSKTM_ADDR_HALF) begin
      q = FSKTM_ADDR_HALF - addr_i;
    end else if (addr_i <= FSKTM_ADDR_Q3) begin
      q = addr_i - FSKTM_ADDR_HALF;
    end else begin
      q = FSKTM_ADDR_FULL - addr_i;
    end
    v = qtr_val(q);
    if (addr_i > FSKTM_ADDR_HALF) begin
      st_nxt.q = 8'(FSKTM_WRAP - {1'b0, v});
    end else begin
      st_nxt.q = v;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      st_r.q <= FSKTM_MID;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign data_o = st_r.q;

endmodule : fsktm_sine_rom

// [verilog/fsktm_core.sv]
// Two-tone modem core: tone modulator, half-cycle demodulator, carrier detect.
`timescale 1ns/1ps
module fsktm_core import fsktm_pkg::*; #(
  parameter int REF_CLK_HZ = FSKTM_CLK_HZ,
  parameter int CNT_W = 16,
  parameter int TMR_W = 20,
  parameter int HALF_LOW_CYC = REF_CLK_HZ / (2 * FSKTM_LOW_TONE_HZ),
  parameter int HALF_HIGH_CYC = REF_CLK_HZ / (2 * FSKTM_HIGH_TONE_HZ),
  parameter int BIT_CYC = REF_CLK_HZ / FSKTM_BAUD,
  parameter int CAR_HOLD_CYC = REF_CLK_HZ / FSKTM_BAUD
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // Host side
  input wire logic tx_req_n_i,
  input wire logic tx_data_i,
  output logic rx_data_o,
  output logic carrier_present_n_o,
  // Line side
  input wire logic rx_cmp_i,
  output logic [7:0] tx_sample_o,
  output logic tx_carrier_on_o
);

  // ===========================================================================
  // Derived counts
  localparam logic [CNT_W-1:0] LOW_TERM_V =
    CNT_W'(REF_CLK_HZ / (FSKTM_LOW_TONE_HZ * FSKTM_SINE_WORDS) - 1);
  localparam logic [CNT_W-1:0] HIGH_TERM_V =
    CNT_W'(REF_CLK_HZ / (FSKTM_HIGH_TONE_HZ * FSKTM_SINE_WORDS) - 1);
  localparam int LO_DEV = HALF_LOW_CYC * FSKTM_TOL_PCT / FSKTM_PCT_FULL;
  localparam int HI_DEV = HALF_HIGH_CYC * FSKTM_TOL_PCT / FSKTM_PCT_FULL;
  localparam logic [TMR_W-1:0] LO_MIN_V = TMR_W'(HALF_LOW_CYC - LO_DEV);
  localparam logic [TMR_W-1:0] LO_MAX_V = TMR_W'(HALF_LOW_CYC + LO_DEV);
  localparam logic [TMR_W-1:0] HI_MIN_V = TMR_W'(HALF_HIGH_CYC - HI_DEV);
  localparam logic [TMR_W-1:0] HI_MAX_V = TMR_W'(HALF_HIGH_CYC + HI_DEV);
  localparam logic [TMR_W-1:0] BIT_LAST_V = TMR_W'(BIT_CYC - 1);
  localparam logic [TMR_W-1:0] CAR_LAST_V = TMR_W'(CAR_HOLD_CYC - 1);

  // ===========================================================================
  // State
  typedef struct packed {
    logic req_s1;
    logic req_s2;
    logic dat_s1;
    logic dat_s2;
    logic cmp_s1;
    logic cmp_s2;
    logic cmp_d;
    logic [CNT_W-1:0] lo_cnt;
    logic [CNT_W-1:0] hi_cnt;
    logic [6:0] addr;
    logic [TMR_W-1:0] half_cnt;
    logic os_busy;
    logic [TMR_W-1:0] os_cnt;
    logic rx_data;
    logic [TMR_W-1:0] car_cnt;
    logic car_n;
  } fsktm_st_t;

  fsktm_st_t st_r;
  fsktm_st_t st_nxt;

  logic lo_tick;
  logic hi_tick;
  logic addr_step;
  logic cmp_edge;
  logic hit_lo;
  logic hit_hi;
  logic tone_hit;

  // ===========================================================================
  // Modulator ticks; both dividers run so a data change takes effect at once.
  assign lo_tick = st_r.lo_cnt == LOW_TERM_V;
  assign hi_tick = st_r.hi_cnt == HIGH_TERM_V;
  assign addr_step = !st_r.req_s2 &&
                     (st_r.dat_s2 ? lo_tick : hi_tick);

  // ===========================================================================
  // Demodulator classification at each comparator edge.
  assign cmp_edge = st_r.cmp_s2 ^ st_r.cmp_d;
  assign hit_lo = cmp_edge && (st_r.half_cnt >= LO_MIN_V) &&
                  (st_r.half_cnt <= LO_MAX_V);
  assign hit_hi = cmp_edge && (st_r.half_cnt >= HI_MIN_V) &&
                  (st_r.half_cnt <= HI_MAX_V);
  assign tone_hit = hit_lo || hit_hi;

  always_comb begin
    st_nxt = st_r;
    st_nxt.req_s1 = tx_req_n_i;
    st_nxt.req_s2 = st_r.req_s1;
    st_nxt.dat_s1 = tx_data_i;
    st_nxt.dat_s2 = st_r.dat_s1;
    st_nxt.cmp_s1 = rx_cmp_i;
    st_nxt.cmp_s2 = st_r.cmp_s1;
    st_nxt.cmp_d = st_r.cmp_s2;
    // The request passes only two flops, far inside five bit times.
    if (st_r.req_s2) begin
      st_nxt.lo_cnt = '0;
      st_nxt.hi_cnt = '0;
      st_nxt.addr = '0;
    end else begin
      st_nxt.lo_cnt = lo_tick ? '0 : st_r.lo_cnt + 1'b1;
      st_nxt.hi_cnt = hi_tick ? '0 : st_r.hi_cnt + 1'b1;
      if (addr_step) begin
        st_nxt.addr = (st_r.addr == FSKTM_ADDR_LAST) ? '0 :
                      st_r.addr + 1'b1;
      end
    end
    // Half-cycle timer saturates so a dead line never aliases into a window.
    if (cmp_edge) begin
      st_nxt.half_cnt = '0;
    end else if (st_r.half_cnt != '1) begin
      st_nxt.half_cnt = st_r.half_cnt + 1'b1;
    end
    // Bit one-shot: a hit while idle starts one bit-long pulse.
    if (!st_r.os_busy && tone_hit) begin
      st_nxt.os_busy = 1'b1;
      st_nxt.os_cnt = BIT_LAST_V;
      st_nxt.rx_data = hit_lo;
    end else if (st_r.os_busy) begin
      if (st_r.os_cnt == '0) begin
        st_nxt.os_busy = 1'b0;
      end else begin
        st_nxt.os_cnt = st_r.os_cnt - 1'b1;
      end
    end
    // Carrier detect holds for one bit after the last recognised half-cycle.
    if (tone_hit) begin
      st_nxt.car_cnt = CAR_LAST_V;
      st_nxt.car_n = 1'b0;
    end else if (st_r.car_cnt != '0) begin
      st_nxt.car_cnt = st_r.car_cnt - 1'b1;
    end else begin
      st_nxt.car_n = 1'b1;
      if (!st_r.os_busy) begin
        st_nxt.rx_data = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      st_r <= '0;
      st_r.req_s1 <= 1'b1;
      st_r.req_s2 <= 1'b1;
      st_r.rx_data <= 1'b1;
      st_r.car_n <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ===========================================================================
  // Sine table; address zero is the quiescent mid level.
  fsktm_sine_rom i_fsktm_sine_rom (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .addr_i(st_r.addr),
    .data_o(tx_sample_o)
  );

  assign rx_data_o = st_r.rx_data;
  assign carrier_present_n_o = st_r.car_n;
  assign tx_carrier_on_o = !st_r.req_s2;

  // ===========================================================================
  // Checks
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_n_i);

  low_tone_hold_a: assert property (
    (!st_r.req_s2 && st_r.dat_s2 && !lo_tick && !$rose(st_r.req_s2))
    |=> (st_r.req_s2 || st_r.addr == $past(st_r.addr)))
    else $error("address moved without a low-tone tick");

  high_tone_step_a: assert property (
    (!st_r.req_s2 && !st_r.dat_s2 && hi_tick && st_r.addr != FSKTM_ADDR_LAST)
    |=> (st_r.req_s2 || st_r.addr == $past(st_r.addr) + 7'h01))
    else $error("high-tone tick did not step address");

  addr_wrap_a: assert property (
    (addr_step && st_r.addr == FSKTM_ADDR_LAST) |=> st_r.addr == '0)
    else $error("sine address did not wrap");

  term_value_a: assert property (
    st_r.lo_cnt <= LOW_TERM_V && st_r.hi_cnt <= HIGH_TERM_V)
    else $error("tone counter passed its terminal value");

  class_excl_a: assert property (
    !(hit_lo && hit_hi))
    else $error("both classifiers fired together");

  one_shot_start_a: assert property (
    (tone_hit && !st_r.os_busy)
    |=> (st_r.os_busy && st_r.os_cnt == BIT_LAST_V
         && st_r.rx_data == $past(hit_lo)))
    else $error("one-shot did not start on a tone hit");

  one_shot_end_a: assert property (
    (st_r.os_busy && st_r.os_cnt == '0) |=> !st_r.os_busy)
    else $error("one-shot overran its bit period");

  carrier_set_a: assert property (
    tone_hit |=> !carrier_present_n_o [*2])
    else $error("carrier detect missed a tone");

  carrier_drop_a: assert property (
    (!tone_hit && st_r.car_cnt == '0) |=> carrier_present_n_o)
    else $error("carrier detect stuck after hold");

  carrier_start_a: assert property (
    $fell(st_r.req_s2) |-> ##[1:1000] (addr_step || st_r.req_s2))
    else $error("carrier did not start in time");

  idle_quiet_a: assert property (
    st_r.req_s2 [*3] |-> (tx_sample_o == FSKTM_MID && st_r.addr == '0))
    else $error("output not quiescent while idle");

  carrier_stop_a: assert property (
    $rose(st_r.req_s2) |=> ##1 (tx_sample_o == FSKTM_MID))
    else $error("carrier did not stop in time");

endmodule : fsktm_core

// [verif/fsktm_host_model.sv]
// Serial host model: transmit request handshake and transmit data.
`timescale 1ns/1ps
module fsktm_host_model (
  // Clock
  input wire logic clk_sys_i,
  // Commands from the bench
  input wire logic send_i,
  input wire logic bit_i,
  // Modem host pins
  output logic tx_req_n_o,
  output logic tx_data_o
);
  logic req_n_r = 1'b1;
  logic dat_r = 1'b0;
  // ======
  // Pin drive
  // Data toggles while idle so an ignored line never looks steady.
  always @(posedge clk_sys_i) begin
    req_n_r <= ~send_i;
    dat_r <= send_i ? bit_i : ~dat_r;
  end
  assign tx_req_n_o = req_n_r;
  assign tx_data_o = dat_r;
endmodule : fsktm_host_model

// [verif/tb_fsktm_core.sv]
// Self-checking bench of the two-tone modem core.
`timescale 1ns/1ps
module tb_fsktm_core import fsktm_pkg::*; ();
  // ======
  // Shortened counts keep the run well under the cycle budget.
  localparam int REF_HZ = 32'h00B7_1B00;
  localparam int H_LOW = 32'h0000_003C;
  localparam int H_HIGH = 32'h0000_0021;
  localparam int BIT = 32'h0000_00C8;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic send = 1'b0;
  logic send_bit = 1'b0;
  logic rx_cmp = 1'b0;
  logic tx_req_n;
  logic tx_data;
  logic rx_data;
  logic car_n;
  logic [7:0] sample;
  logic car_on;
  int bad_count = 0;
  int compares = 0;
  always #5 clk_sys = ~clk_sys;
  fsktm_host_model i_fsktm_host_model (.clk_sys_i(clk_sys), .send_i(send),
    .bit_i(send_bit), .tx_req_n_o(tx_req_n), .tx_data_o(tx_data));
  fsktm_core #(.REF_CLK_HZ(REF_HZ), .HALF_LOW_CYC(H_LOW),
    .HALF_HIGH_CYC(H_HIGH), .BIT_CYC(BIT), .CAR_HOLD_CYC(BIT)) i_fsktm_core (
    .clk_sys_i(clk_sys), .rst_n_i(rst_n), .tx_req_n_i(tx_req_n),
    .tx_data_i(tx_data), .rx_data_o(rx_data), .carrier_present_n_o(car_n),
    .rx_cmp_i(rx_cmp), .tx_sample_o(sample), .tx_carrier_on_o(car_on));
  // ======
  // Shared tasks
  task automatic summarize();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : summarize
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic tick();
    @(posedge clk_sys);
    #1;
  endtask : tick
  task automatic expire(input int n, input int lim);
    if (n >= lim) begin
      bad_count++;
      summarize();
    end
  endtask : expire
  // ======
  // Scenarios
  task automatic t_quiet();
    int moved;
    moved = 0;
    repeat (300) begin
      tick();
      if (sample !== 8'h80 || car_on !== 1'b0) moved = 1;
    end
    check(32'(moved), 32'h0);
  endtask : t_quiet
  task automatic t_tone(input logic b, input int step);
    int n;
    logic [7:0] prev;
    @(posedge clk_sys);
    send <= 1'b1;
    send_bit <= b;
    n = 0;
    while (car_on !== 1'b1 && n < 5 * BIT) begin
      tick();
      n++;
    end
    expire(n, 5 * BIT);
    n = 0;
    while (sample === 8'h80 && n < 4 * step) begin
      tick();
      n++;
    end
    expire(n, 4 * step);
    prev = sample;
    n = 0;
    while (sample === prev && n < 4 * step) begin
      tick();
      n++;
    end
    check(32'(n), 32'(step));
    @(posedge clk_sys);
    send <= 1'b0;
    n = 0;
    while (car_on !== 1'b0 && n < 5 * BIT) begin
      tick();
      n++;
    end
    expire(n, 5 * BIT);
    tick();
    tick();
    check(32'(sample), 32'h80);
  endtask : t_tone
  task automatic t_demod(input int half, input logic b);
    int n;
    int stay;
    repeat (4) begin
      repeat (half) @(posedge clk_sys);
      rx_cmp <= ~rx_cmp;
    end
    tick();
    check(32'(car_n), 32'h0);
    check(32'(rx_data), 32'(b));
    stay = 1;
    repeat (BIT - 2 * half - 8) begin
      tick();
      if (rx_data !== b) stay = 0;
    end
    check(32'(stay), 32'h1);
    n = 0;
    while (car_n !== 1'b1 && n < 3 * BIT) begin
      tick();
      n++;
    end
    expire(n, 3 * BIT);
    repeat (BIT) tick();
    check(32'(rx_data), 32'h1);
  endtask : t_demod
  task automatic t_stray();
    int hit;
    hit = 0;
    repeat (6) begin
      repeat (45) @(posedge clk_sys);
      rx_cmp <= ~rx_cmp;
    end
    repeat (8) begin
      tick();
      if (car_n !== 1'b1) hit = 1;
    end
    check(32'(hit), 32'h0);
  endtask : t_stray
  // ======
  // Main sequence
  initial begin
    repeat (4) tick();
    check(32'(rx_data), 32'h1);
    check(32'(car_n), 32'h1);
    check(32'(sample), 32'h80);
    check(32'(car_on), 32'h0);
    @(posedge clk_sys);
    rst_n <= 1'b1;
    t_quiet();
    t_tone(1'b1, REF_HZ / (FSKTM_LOW_TONE_HZ * FSKTM_SINE_WORDS));
    t_tone(1'b0, REF_HZ / (FSKTM_HIGH_TONE_HZ * FSKTM_SINE_WORDS));
    t_quiet();
    t_demod(H_HIGH, 1'b0);
    t_demod(H_LOW, 1'b1);
    t_stray();
    summarize();
  end
endmodule : tb_fsktm_core
